// file: gcg_pkg.sv
// Purpose: Shared constants for the gated counter with gate and overflow logic
// Assumes: 8-bit register port, byte addresses, one clock
// Notes: Contract list below
//
// Contract
// R1 - Gating applies only while gate_enable is set, else counter runs freely.
// R2 - Gate active means increment each clock; gate inactive means hold.
// R3 - Polarity 0 counts on low gate; polarity 1 counts on high gate.
// R4 - Source select: 00 pin, 01 timer overflow, 10 comparator one, 11 comparator two.
// R5 - Eight-bit timer wrapping FFh to 00h makes a gate pulse.
// R6 - Each comparator output reaches the gate synchronised or direct, per configuration.
// R7 - Toggle mode: flip-flop inverts on each incrementing gate edge.
// R8 - Toggle flip-flop held at zero while toggle enable is clear.
// R9 - Software sets single-pulse enable then arm; counting starts at next incrementing edge.
// R10 - Arm bit clears on trailing gate edge; counting blocked until re-armed.
// R11 - Software clears arm bit when it disables single-pulse mode.
// R12 - Toggle plus single-pulse counts exactly one full gate period per arming.
// R13 - Software never enables toggle in the same write that changes polarity.
// R14 - Resolved gate level is readable, even with gate_enable clear.
// R15 - Falling resolved gate sets gate event flag; interrupt if enabled.
// R16 - Gate event flag logic works with gate_enable clear.
// R17 - Counter wraps FFFFh to 0000h and sets overflow flag.
// R18 - Overflow interrupt needs counter_on, overflow, peripheral and global enables.
// R19 - Software clears counter and overflow flag before enabling overflow interrupt.
// R20 - Counter off when counter_on clear; else free or gated per gate_enable.
// R21 - Gate resolved as select, polarity, toggle, single pulse; drives count and status.

package gcg_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 3;
    localparam int CNT_W = 16;

    // Register byte addresses
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_GATE = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_CNT_LO = 3'h2;
    localparam logic [ADDR_W-1:0] ADDR_CNT_HI = 3'h3;
    localparam logic [ADDR_W-1:0] ADDR_FLAG = 3'h4;
    localparam logic [ADDR_W-1:0] ADDR_IEN = 3'h5;
    localparam logic [ADDR_W-1:0] ADDR_IRQC = 3'h6;

    // counter_control_reg fields
    localparam int BIT_ON = 0;
    localparam int BIT_C1_SYNC = 1;
    localparam int BIT_C2_SYNC = 2;

    // gate_control_reg fields
    localparam int BIT_GE = 7;
    localparam int BIT_POL = 6;
    localparam int BIT_TM = 5;
    localparam int BIT_SPM = 4;
    localparam int BIT_ARM = 3;
    localparam int BIT_VAL = 2;
    localparam int SEL_HI = 1;
    localparam int SEL_LO = 0;

    // Flag and enable fields
    localparam int BIT_OVF = 0;
    localparam int BIT_GEV = 7;

    // irq_control_reg fields
    localparam int BIT_GIE = 7;
    localparam int BIT_PERIPHERAL_IRQ_ENABLE = 6;

    // Gate source codes
    localparam logic [1:0] SRC_PIN = 2'h0;
    localparam logic [1:0] SRC_TMR = 2'h1;
    localparam logic [1:0] SRC_CMP1 = 2'h2;
    localparam logic [1:0] SRC_CMP2 = 2'h3;

    localparam logic [7:0] TMR_TOP = 8'hff;
    localparam logic [7:0] TMR_ZERO = 8'h00;
    localparam logic [CNT_W-1:0] CNT_TOP = 16'hffff;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
    localparam logic [DATA_W-1:0] REG_RST = 8'h00;
endpackage : gcg_pkg

// file: gcg_sync.sv
// Purpose: Two-flop level synchroniser
// Assumes: Asynchronous level input
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none

module gcg_sync
(
    input wire logic clk,
    input wire logic rst,
    input wire logic d,
    output logic q
);
    logic meta_ff;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            meta_ff <= 1'b0;
            q <= 1'b0;
        end
        else
        begin
            meta_ff <= d;
            q <= meta_ff;
        end
    end
endmodule // gcg_sync
`default_nettype wire

// file: gcg_top.sv
// Purpose: Gate control, gate event and overflow interrupt for a 16-bit counter
// Assumes: Counter clock is clk; register port with read data one cycle later
// Notes: Hardware flag set wins over software clear
`timescale 1ns/1ps
`default_nettype none

module gcg_top
    import gcg_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [DATA_W-1:0] rdata,
    input wire logic gate_pin,
    input wire logic [7:0] eight_bit_timer,
    input wire logic comparator_one_out,
    input wire logic comparator_two_out,
    output logic [CNT_W-1:0] count,
    output logic gate_level_status,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    // Register state

    logic counter_on_ff;
    logic [1:0] cmp_sync_en_ff;
    logic gate_enable_ff;
    logic gate_polarity_ff;
    logic gate_toggle_enable_ff;
    logic gate_single_pulse_enable_ff;
    logic gate_arm_done_ff;
    logic [1:0] gate_source_select_ff;
    logic overflow_flag_ff;
    logic gate_event_flag_ff;
    logic overflow_irq_enable_ff;
    logic gate_event_irq_enable_ff;
    logic peripheral_irq_enable_ff;
    logic global_irq_enable_ff;
    logic [CNT_W-1:0] count_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic irq_ff;

    // Gate path state
    logic [7:0] tmr_prev_ff;
    logic tmr_ovf_ff;
    logic pol_prev_ff;
    logic toggle_ff;
    logic pre_prev_ff;
    logic sp_run_ff;
    logic resolved_ff;

    logic wr_ctrl;
    logic wr_gate;
    logic wr_lo;
    logic wr_hi;
    logic wr_flag;
    logic wr_ien;
    logic wr_irqc;

    assign wr_ctrl = wr && (addr == ADDR_CTRL);
    assign wr_gate = wr && (addr == ADDR_GATE);
    assign wr_lo = wr && (addr == ADDR_CNT_LO);
    assign wr_hi = wr && (addr == ADDR_CNT_HI);
    assign wr_flag = wr && (addr == ADDR_FLAG);
    assign wr_ien = wr && (addr == ADDR_IEN);
    assign wr_irqc = wr && (addr == ADDR_IRQC);

    ////////////////////////////////////////////////////////////////////////
    // Comparator paths

    logic [1:0] cmp_raw;
    logic [1:0] cmp_synced;
    logic [1:0] cmp_gate;

    assign cmp_raw = {comparator_two_out, comparator_one_out};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_cmp
            gcg_sync u_sync
            (
                .clk(clk),
                .rst(rst),
                .d(cmp_raw[gi]),
                .q(cmp_synced[gi])
            );
            // R6 sync or direct
            assign cmp_gate[gi] = cmp_sync_en_ff[gi] ? cmp_synced[gi] : cmp_raw[gi];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Timer overflow pulse

    // R5 wrap detect
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            tmr_prev_ff <= TMR_ZERO;
            tmr_ovf_ff <= 1'b0;
        end
        else
        begin
            tmr_prev_ff <= eight_bit_timer;
            tmr_ovf_ff <= (tmr_prev_ff == TMR_TOP) && (eight_bit_timer == TMR_ZERO);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Gate resolution chain

    logic src_level;
    logic pol_level;
    logic pre_level;
    logic pre_rise;
    logic nxt_resolved;
    logic resolved_fall;

    // R4 source select
    always_comb
    begin
        case (gate_source_select_ff)
            SRC_PIN: src_level = gate_pin;
            SRC_TMR: src_level = tmr_ovf_ff;
            SRC_CMP1: src_level = cmp_gate[0];
            SRC_CMP2: src_level = cmp_gate[1];
            default: src_level = gate_pin;
        endcase
    end

    // R3 polarity
    assign pol_level = gate_polarity_ff ? src_level : ~src_level;

    // R7 toggle on edge
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pol_prev_ff <= 1'b0;
            toggle_ff <= 1'b0;
        end
        else
        begin
            pol_prev_ff <= pol_level;
            // R8 held clear
            if (!gate_toggle_enable_ff)
            begin
                toggle_ff <= 1'b0;
            end
            else if (pol_level && !pol_prev_ff)
            begin
                toggle_ff <= ~toggle_ff;
            end
        end
    end

    // R21 resolution order
    assign pre_level = gate_toggle_enable_ff ? toggle_ff : pol_level;
    assign pre_rise = pre_level && !pre_prev_ff;

    // R9 start on edge
    // R12 one period
    always_comb
    begin
        if (gate_single_pulse_enable_ff)
        begin
            nxt_resolved = pre_level && gate_arm_done_ff && (sp_run_ff || pre_rise);
        end
        else
        begin
            nxt_resolved = pre_level;
        end
    end

    assign resolved_fall = resolved_ff && !nxt_resolved;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pre_prev_ff <= 1'b0;
            sp_run_ff <= 1'b0;
        end
        else
        begin
            pre_prev_ff <= pre_level;
            if (!gate_single_pulse_enable_ff || !gate_arm_done_ff || resolved_fall)
            begin
                sp_run_ff <= 1'b0;
            end
            else if (pre_rise)
            begin
                sp_run_ff <= 1'b1;
            end
        end
    end

    // R14 level status
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            resolved_ff <= 1'b0;
        end
        else
        begin
            resolved_ff <= nxt_resolved;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control registers

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            counter_on_ff <= 1'b0;
            cmp_sync_en_ff <= 2'h0;
        end
        else if (wr_ctrl)
        begin
            counter_on_ff <= wdata[BIT_ON];
            cmp_sync_en_ff <= {wdata[BIT_C2_SYNC], wdata[BIT_C1_SYNC]};
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            gate_enable_ff <= 1'b0;
            gate_polarity_ff <= 1'b0;
            gate_toggle_enable_ff <= 1'b0;
            gate_single_pulse_enable_ff <= 1'b0;
            gate_source_select_ff <= SRC_PIN;
        end
        else if (wr_gate)
        begin
            gate_enable_ff <= wdata[BIT_GE];
            gate_polarity_ff <= wdata[BIT_POL];
            gate_toggle_enable_ff <= wdata[BIT_TM];
            gate_single_pulse_enable_ff <= wdata[BIT_SPM];
            gate_source_select_ff <= wdata[SEL_HI:SEL_LO];
        end
    end

    // R10 done on trailing edge
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            gate_arm_done_ff <= 1'b0;
        end
        else if (wr_gate)
        begin
            gate_arm_done_ff <= wdata[BIT_ARM];
        end
        else if (gate_single_pulse_enable_ff && resolved_fall)
        begin
            gate_arm_done_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            overflow_irq_enable_ff <= 1'b0;
            gate_event_irq_enable_ff <= 1'b0;
        end
        else if (wr_ien)
        begin
            overflow_irq_enable_ff <= wdata[BIT_OVF];
            gate_event_irq_enable_ff <= wdata[BIT_GEV];
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            peripheral_irq_enable_ff <= 1'b0;
            global_irq_enable_ff <= 1'b0;
        end
        else if (wr_irqc)
        begin
            peripheral_irq_enable_ff <= wdata[BIT_PERIPHERAL_IRQ_ENABLE];
            global_irq_enable_ff <= wdata[BIT_GIE];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Counter

    logic count_en;
    logic wrap;

    // R1 R2 R20 count enable
    assign count_en = counter_on_ff && (!gate_enable_ff || resolved_ff);
    // R17 wrap detect
    assign wrap = count_en && (count_ff == CNT_TOP);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            count_ff <= CNT_RST;
        end
        else if (wr_lo)
        begin
            count_ff <= {count_ff[CNT_W-1:DATA_W], wdata};
        end
        else if (wr_hi)
        begin
            count_ff <= {wdata, count_ff[DATA_W-1:0]};
        end
        else if (count_en)
        begin
            count_ff <= count_ff + CNT_ONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Event flags

    // R17 overflow flag
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            overflow_flag_ff <= 1'b0;
        end
        else if (wrap)
        begin
            overflow_flag_ff <= 1'b1;
        end
        else if (wr_flag)
        begin
            overflow_flag_ff <= wdata[BIT_OVF];
        end
    end

    // R15 R16 gate event flag
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            gate_event_flag_ff <= 1'b0;
        end
        else if (resolved_fall)
        begin
            gate_event_flag_ff <= 1'b1;
        end
        else if (wr_flag)
        begin
            gate_event_flag_ff <= wdata[BIT_GEV];
        end
    end

    // R18 overflow irq qualify
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            irq_ff <= 1'b0;
        end
        else
        begin
            irq_ff <= global_irq_enable_ff && peripheral_irq_enable_ff &&
                ((overflow_flag_ff && overflow_irq_enable_ff && counter_on_ff) ||
                 (gate_event_flag_ff && gate_event_irq_enable_ff));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port

    logic [DATA_W-1:0] rd_mux;

    always_comb
    begin
        rd_mux = REG_RST;
        case (addr)
            ADDR_CTRL:
            begin
                rd_mux[BIT_ON] = counter_on_ff;
                rd_mux[BIT_C1_SYNC] = cmp_sync_en_ff[0];
                rd_mux[BIT_C2_SYNC] = cmp_sync_en_ff[1];
            end
            ADDR_GATE:
            begin
                rd_mux[BIT_GE] = gate_enable_ff;
                rd_mux[BIT_POL] = gate_polarity_ff;
                rd_mux[BIT_TM] = gate_toggle_enable_ff;
                rd_mux[BIT_SPM] = gate_single_pulse_enable_ff;
                rd_mux[BIT_ARM] = gate_arm_done_ff;
                rd_mux[BIT_VAL] = resolved_ff;
                rd_mux[SEL_HI:SEL_LO] = gate_source_select_ff;
            end
            ADDR_CNT_LO: rd_mux = count_ff[DATA_W-1:0];
            ADDR_CNT_HI: rd_mux = count_ff[CNT_W-1:DATA_W];
            ADDR_FLAG:
            begin
                rd_mux[BIT_OVF] = overflow_flag_ff;
                rd_mux[BIT_GEV] = gate_event_flag_ff;
            end
            ADDR_IEN:
            begin
                rd_mux[BIT_OVF] = overflow_irq_enable_ff;
                rd_mux[BIT_GEV] = gate_event_irq_enable_ff;
            end
            ADDR_IRQC:
            begin
                rd_mux[BIT_GIE] = global_irq_enable_ff;
                rd_mux[BIT_PERIPHERAL_IRQ_ENABLE] = peripheral_irq_enable_ff;
            end
            default: rd_mux = REG_RST;
        endcase
    end

    // Data valid only the cycle after rd
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rdata_ff <= REG_RST;
        end
        else if (rd)
        begin
            rdata_ff <= rd_mux;
        end
        else
        begin
            rdata_ff <= REG_RST;
        end
    end

    assign rdata = rdata_ff;
    assign count = count_ff;
    assign gate_level_status = resolved_ff;
    assign irq = irq_ff;

endmodule // gcg_top
`default_nettype wire

// file: gcg_top_properties.sv
// Purpose: Port properties of the gate and overflow block
// Assumes: Control shadows rebuilt from register writes
// Notes: Bound to gcg_top below
`timescale 1ns/1ps
`default_nettype none

module gcg_top_properties
    import gcg_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic [7:0] eight_bit_timer,
    input wire logic gate_pin,
    input wire logic [CNT_W-1:0] count,
    input wire logic gate_level_status,
    input wire logic irq
);
    logic on_ff, ge_ff, pol_ff, tm_ff, spm_ff, ovfie_ff, gevie_ff, glob_ff, peri_ff;
    logic [1:0] sel_ff;
    logic gate_wr, cnt_wr, cnt_en, pin_path, tmr_path;

    assign gate_wr = wr && addr == ADDR_GATE;
    assign cnt_wr = wr && (addr == ADDR_CNT_LO || addr == ADDR_CNT_HI);
    assign cnt_en = on_ff && (!ge_ff || gate_level_status);
    assign pin_path = sel_ff == SRC_PIN && !tm_ff && !spm_ff;
    assign tmr_path = sel_ff == SRC_TMR && pol_ff && !tm_ff && !spm_ff;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            {on_ff, ge_ff, pol_ff, tm_ff, spm_ff, sel_ff} <= 7'h00;
            {ovfie_ff, gevie_ff, glob_ff, peri_ff} <= 4'h0;
        end
        else if (wr)
        begin
            if (addr == ADDR_CTRL)
                on_ff <= wdata[BIT_ON];
            if (gate_wr)
                {ge_ff, pol_ff, tm_ff, spm_ff, sel_ff} <= {wdata[7:4], wdata[1:0]};
            if (addr == ADDR_IEN)
                {gevie_ff, ovfie_ff} <= {wdata[BIT_GEV], wdata[BIT_OVF]};
            if (addr == ADDR_IRQC)
                {glob_ff, peri_ff} <= wdata[7:6];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_wrap;
        $past(eight_bit_timer) == TMR_TOP && eight_bit_timer == TMR_ZERO;
    endsequence
    sequence s_done;
        spm_ff && !gate_wr && $fell(gate_level_status);
    endsequence

    AST_COUNT_STEP: assert property (
        !$past(rst) && !$past(cnt_wr) |-> count == $past(count) + {15'h0, $past(cnt_en)})
        else $error("count step wrong");
    AST_FREE_RUN: assert property (
        (on_ff && !ge_ff && !cnt_wr)[*3] |=> count == $past(count, 3) + 16'h0003)
        else $error("free run count wrong");
    AST_PIN_LEVEL: assert property (
        !$past(rst) && $past(pin_path) |-> gate_level_status == ($past(gate_pin) ~^ $past(pol_ff)))
        else $error("gate level wrong");
    AST_TMR_PULSE: assert property (
        s_wrap ##0 tmr_path |-> ##[1:3] gate_level_status)
        else $error("no timer pulse");
    AST_SP_BLOCK: assert property (
        s_done ##1 (!gate_wr)[*6] |-> !gate_level_status)
        else $error("count after done");
    AST_IRQ_GATED: assert property (
        irq |-> $past(glob_ff) && $past(peri_ff))
        else $error("irq without enables");
    AST_OVF_IRQ: assert property (
        $past(count) == CNT_TOP && count == CNT_RST && !$past(cnt_wr) && on_ff && ovfie_ff && glob_ff && peri_ff
        |-> ##[0:2] irq)
        else $error("no overflow irq");
    AST_GEV_IRQ: assert property (
        $fell(gate_level_status) && gevie_ff && glob_ff && peri_ff |-> ##[0:2] irq)
        else $error("no gate event irq");
endmodule // gcg_top_properties

bind gcg_top gcg_top_properties i_gcg_top_properties (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .eight_bit_timer(eight_bit_timer), .gate_pin(gate_pin), .count(count),
    .gate_level_status(gate_level_status), .irq(irq));
`default_nettype wire

// file: gcg_far.sv
// Purpose: Far side sources of the gate
// Assumes: Levels and wave chosen by the bench
// Notes: All outputs registered
`timescale 1ns/1ps
`default_nettype none

module gcg_far
(
    input wire logic clk,
    input wire logic rst,
    input wire logic wave,
    input wire logic [2:0] lvl,
    output logic gate_pin,
    output logic [7:0] eight_bit_timer,
    output logic comparator_one_out,
    output logic comparator_two_out
);
    logic [1:0] ph_ff;
    logic tgl_ff;

    // Free running timer
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            eight_bit_timer <= 8'h00;
        else
            eight_bit_timer <= eight_bit_timer + 8'h01;
    end

    // Square wave, four high, four low
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst || !wave)
        begin
            ph_ff <= 2'h0;
            tgl_ff <= 1'b0;
        end
        else
        begin
            ph_ff <= ph_ff + 2'h1;
            if (ph_ff == 2'h3)
                tgl_ff <= ~tgl_ff;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            {gate_pin, comparator_one_out, comparator_two_out} <= 3'h0;
        else
            {gate_pin, comparator_one_out, comparator_two_out} <= {wave ? tgl_ff : lvl[0], lvl[1], lvl[2]};
    end
endmodule // gcg_far
`default_nettype wire

// file: test_gcg_top.sv
// Purpose: Self-checking bench of the gate block
// Assumes: Read data one cycle after the strobe
// Notes: Gate table first, then hand cases
`timescale 1ns/1ps
`default_nettype none

`define CHK(n, e, g) \
    begin \
        compares++; \
        if ((g) !== (e)) \
        begin \
            n_fail++; \
            $display("wrong value %s exp %0h got %0h", n, e, g); \
        end \
    end

module test_gcg_top
    import gcg_pkg::*;
;
    typedef struct packed {logic [1:0] sel; logic pol; logic lvl; logic sync; logic exp;} gcg_row_s;
    localparam gcg_row_s ROWS [10] = '{6'h01, 6'h04, 6'h08, 6'h0d, 6'h2f, 6'h24, 6'h28, 6'h3d, 6'h33, 6'h3a};
    logic clk, rst, wr, rd, wave, gate_pin, cmp1, cmp2, gate_level_status, irq;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, d;
    logic [2:0] lvl, m;
    logic [7:0] tmr;
    logic [CNT_W-1:0] count, c0;
    int n_fail, compares, i;

    gcg_top i_gcg_top (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .gate_pin(gate_pin), .eight_bit_timer(tmr), .comparator_one_out(cmp1), .comparator_two_out(cmp2),
        .count(count), .gate_level_status(gate_level_status), .irq(irq));
    gcg_far i_gcg_far (.clk(clk), .rst(rst), .wave(wave), .lvl(lvl), .gate_pin(gate_pin),
        .eight_bit_timer(tmr), .comparator_one_out(cmp1), .comparator_two_out(cmp2));

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wreg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
        @(posedge clk);
        {wr, addr, wdata} <= {1'b1, a, v};
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [ADDR_W-1:0] a);
        @(posedge clk);
        {rd, addr} <= {1'b1, a};
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic span(input int n, input logic [CNT_W-1:0] inc);
        c0 = count;
        cyc(n);
        `CHK("count", c0 + inc, count)
    endtask
    task automatic report_and_stop;
        if (n_fail == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial
    begin
        #400000;
        n_fail++;
        report_and_stop;
    end

    initial
    begin
        rst = 1'b1;
        {wr, rd, wave} = 3'h0;
        {addr, lvl} = 6'h00;
        wdata = 8'h00;
        n_fail = 0;
        compares = 0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i < 10; i++)
        begin
            wreg(ADDR_CTRL, {5'h00, {2{ROWS[i].sync}}, 1'b1});
            wreg(ADDR_GATE, {1'b1, ROWS[i].pol, 4'h0, ROWS[i].sel});
            m = (ROWS[i].sel == SRC_PIN) ? 3'h1 : (ROWS[i].sel == SRC_CMP1) ? 3'h2 : 3'h4;
            lvl <= ROWS[i].lvl ? m : ~m;
            cyc(3);
            // Synchronised comparator still shows the old level here
            `CHK("early level", ROWS[i].exp & ~ROWS[i].sync, gate_level_status)
            cyc(4);
            `CHK("gate level", ROWS[i].exp, gate_level_status)
            rreg(ADDR_GATE);
            `CHK("status bit", ROWS[i].exp, d[BIT_VAL])
            span(4, {13'h0000, ROWS[i].exp, 2'h0});
        end
        wreg(ADDR_GATE, 8'hc1);
        lvl <= 3'h0;
        cyc(4);
        for (i = 0; i < 300 && tmr !== 8'h80; i++)
            cyc(1);
        span(512, 16'h0002);
        wreg(ADDR_GATE, 8'he0);
        wave <= 1'b1;
        cyc(8);
        span(32, 16'h0010);
        wave <= 1'b0;
        wreg(ADDR_GATE, 8'hc0);
        wreg(ADDR_GATE, 8'hf0);
        wreg(ADDR_GATE, 8'hf8);
        wreg(ADDR_FLAG, 8'h00);
        rreg(ADDR_FLAG);
        `CHK("gate event", 1'b0, d[BIT_GEV])
        cyc(4);
        wave <= 1'b1;
        span(80, 16'h0008);
        rreg(ADDR_GATE);
        `CHK("arm bit", 1'b0, d[BIT_ARM])
        rreg(ADDR_FLAG);
        `CHK("gate event", 1'b1, d[BIT_GEV])
        wave <= 1'b0;
        wreg(ADDR_GATE, 8'hd0);
        wreg(ADDR_GATE, 8'hd8);
        cyc(4);
        wave <= 1'b1;
        span(64, 16'h0004);
        wreg(ADDR_GATE, 8'h40);
        wreg(ADDR_FLAG, 8'h00);
        cyc(20);
        rreg(ADDR_FLAG);
        `CHK("gate event", 1'b1, d[BIT_GEV])
        span(10, 16'h000a);
        wreg(ADDR_IEN, 8'h80);
        wreg(ADDR_IRQC, 8'hc0);
        cyc(3);
        `CHK("irq", 1'b1, irq)
        wave <= 1'b0;
        cyc(12);
        wreg(ADDR_FLAG, 8'h00);
        cyc(3);
        `CHK("irq", 1'b0, irq)
        wreg(ADDR_CTRL, 8'h00);
        cyc(2);
        span(10, 16'h0000);
        wreg(ADDR_CNT_HI, 8'hff);
        wreg(ADDR_CNT_LO, 8'hf0);
        wreg(ADDR_FLAG, 8'h00);
        wreg(ADDR_IEN, 8'h01);
        wreg(ADDR_CTRL, 8'h01);
        cyc(24);
        `CHK("count", 16'h0008, count)
        `CHK("irq", 1'b1, irq)
        rreg(ADDR_FLAG);
        `CHK("overflow", 1'b1, d[BIT_OVF])
        wreg(ADDR_IRQC, 8'h40);
        cyc(2);
        `CHK("irq", 1'b0, irq)
        @(posedge clk);
        rst <= 1'b1;
        cyc(2);
        `CHK("count", 16'h0000, count)
        @(posedge clk);
        rst <= 1'b0;
        wreg(3'h7, 8'hff);
        for (i = 0; i < 8; i++)
        begin
            rreg(i[2:0]);
            `CHK("reset reg", 8'h00, d & 8'hfb)
        end
        report_and_stop;
    end
endmodule // test_gcg_top
`default_nettype wire
